/* logic/host_bus_pkg.sv */
// Shared constants for the parallel host bus port
package host_bus_pkg;
    // Bus style encodings on bus_style_select
    localparam logic [1:0] STYLE_GENERIC = 2'h0;
    localparam logic [1:0] STYLE_ENCLK   = 2'h1;
    localparam logic [1:0] STYLE_ASTROBE = 2'h2;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ADDR_W       = 16;
    // Cycles the device holds its wait answer before completing
    localparam int unsigned ACCESS_CYC   = 3;
    localparam logic [1:0]  ACCESS_CNT   = 2'(ACCESS_CYC);
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [15:0] ADDR_RST     = 16'h0000;
    // Count loaded for the host setup and strobe phases; setup lasts this many cycles plus one, the strobe at least that
    localparam int unsigned HOST_PHASE   = 2;
    localparam logic [2:0]  HOST_CNT     = 3'(HOST_PHASE);
    // Cycles the host waits for an answer before giving up
    localparam logic [5:0]  HOST_TIMEOUT = 6'h3f;
    // Enable-clock reads and writes: no wait pin, so the enable outlasts the access
    localparam logic [5:0]  ENCLK_END    = HOST_TIMEOUT - 6'h08;
endpackage : host_bus_pkg

/* logic/host_bus_if.sv */
// Pin-level carrier joining host and device ends
interface host_bus_if;
    logic [15:0] addr;
    logic [7:0]  data_h;
    logic        data_h_oe_n;
    logic [7:0]  data_d;
    logic        data_d_oe_n;
    logic        rd_pin;
    logic        wr_pin;
    logic        chip_sel_n;
    logic        addr_qualify_n;
    logic        wait_out;
    logic        wait_oe_n;
    logic [1:0]  bus_style_select;
    logic        scan_test_in;
    logic        factory_test_in;

    modport device (
        input  addr, data_h, data_h_oe_n, rd_pin, wr_pin, chip_sel_n, addr_qualify_n,
        input  bus_style_select, scan_test_in, factory_test_in,
        output data_d, data_d_oe_n, wait_out, wait_oe_n
    );
    modport host (
        output addr, data_h, data_h_oe_n, rd_pin, wr_pin, chip_sel_n, addr_qualify_n,
        output bus_style_select, scan_test_in, factory_test_in,
        input  data_d, data_d_oe_n, wait_out, wait_oe_n
    );
endinterface : host_bus_if

/* logic/pin_sync.sv */
// Two-stage synchroniser for a vector of pins
module pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // Reset to all ones, the idle level of the active-low strobes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= pin_i;
            sync_o <= meta_q;
        end
    end
endmodule : pin_sync

/* logic/host_bus_device.sv */
// Device end of the parallel host bus port
module host_bus_device
    import host_bus_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    host_bus_if.device       bus,
    output logic             wr_valid_o,
    output logic [15:0]      wr_addr_o,
    output logic [7:0]       wr_data_o,
    output logic             rd_req_o,
    output logic [15:0]      rd_addr_o,
    input  wire logic [7:0]  rd_data_i,
    output logic [1:0]       style_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} dev_state_e;

    logic [1:0]  ctl_s;
    logic [7:0]  dat_s;
    logic [15:0] adr_s;
    logic [1:0]  cfg_s;
    logic        rd_s, wr_s, cs_n_s, aq_n_s;
    logic        rd_prev_q, wr_prev_q;
    dev_state_e  state_q;
    logic [1:0]  cnt_q;
    logic        is_rd_q;
    logic        ack_done_q;

    // All pins the device reads cross into clk_sys_i through two flops
    pin_sync #(.W(4)) u_sync_ctl (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     ({bus.rd_pin, bus.wr_pin, bus.chip_sel_n, bus.addr_qualify_n}),
        .sync_o    ({rd_s, wr_s, cs_n_s, aq_n_s})
    );
    pin_sync #(.W(8)) u_sync_dat (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (bus.data_h),
        .sync_o    (dat_s)
    );
    pin_sync #(.W(16)) u_sync_adr (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (bus.addr),
        .sync_o    (adr_s)
    );
    pin_sync #(.W(2)) u_sync_cfg (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (bus.bus_style_select),
        .sync_o    (cfg_s)
    );
    assign ctl_s = cfg_s;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
            style_o   <= STYLE_GENERIC;
        end else begin
            rd_prev_q <= rd_s;
            wr_prev_q <= wr_s;
            style_o   <= ctl_s;
        end
    end

    // Edge events per style
    logic gen_wr_rise, gen_wr_fall, gen_rd_fall, en_rise, lds_fall, start_w, start_r, sel;
    logic take_w;
    always_comb begin
        sel         = !cs_n_s;
        gen_wr_rise = sel && !wr_prev_q && wr_s;
        // Busy from the strobe fall, so wait can stall the host
        gen_wr_fall = sel && wr_prev_q && !wr_s;
        gen_rd_fall = sel && rd_prev_q && !rd_s;
        en_rise     = sel && !rd_prev_q && rd_s;
        // Qualify must be low for the address to count
        lds_fall    = sel && !aq_n_s && rd_prev_q && !rd_s;
        start_w     = 1'b0;
        start_r     = 1'b0;
        case (style_o)
            STYLE_GENERIC: begin
                start_w = gen_wr_fall;
                start_r = gen_rd_fall;
            end
            STYLE_ENCLK: begin
                start_w = en_rise && !wr_s;
                start_r = en_rise && wr_s;
            end
            STYLE_ASTROBE: begin
                start_w = lds_fall && !wr_s;
                start_r = lds_fall && wr_s;
            end
            default: begin
                start_w = 1'b0;
                start_r = 1'b0;
            end
        endcase
        // Generic write data is only valid at the strobe rise
        take_w      = (style_o == STYLE_GENERIC) ?
                      (gen_wr_rise && state_q != ST_IDLE && !is_rd_q) :
                      (start_w && state_q == ST_IDLE);
    end

    // Transfer sequencing; chip select drop aborts and releases pins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
            is_rd_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_w || start_r) begin
                        state_q <= ST_BUSY;
                        cnt_q   <= ACCESS_CNT;
                        is_rd_q <= start_r;
                    end
                end
                ST_BUSY: begin
                    if (cs_n_s) begin
                        state_q <= ST_IDLE;
                    end else if (cnt_q == 2'h1) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                ST_DONE: begin
                    // Hold completion until the host ends its strobe
                    if (cs_n_s || (style_o == STYLE_GENERIC ? (rd_s && wr_s) : 
                        (style_o == STYLE_ENCLK ? !rd_s : rd_s))) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // User side strobes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_valid_o <= 1'b0;
            wr_addr_o  <= ADDR_RST;
            wr_data_o  <= DATA_RST;
            rd_req_o   <= 1'b0;
            rd_addr_o  <= ADDR_RST;
        end else begin
            wr_valid_o <= take_w;
            rd_req_o   <= start_r && state_q == ST_IDLE;
            if (take_w) begin
                wr_addr_o <= adr_s;
                wr_data_o <= dat_s;
            end
            if (start_r && state_q == ST_IDLE) begin
                rd_addr_o <= adr_s;
            end
        end
    end

    // Wait or ack pin and read data drivers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus.wait_out    <= 1'b1;
            bus.wait_oe_n   <= 1'b1;
            bus.data_d      <= DATA_RST;
            bus.data_d_oe_n <= 1'b1;
            ack_done_q      <= 1'b0;
        end else begin
            ack_done_q <= state_q == ST_DONE;
            case (style_o)
                STYLE_GENERIC: begin
                    // Low while busy, high when done, then released
                    bus.wait_oe_n <= !(state_q == ST_BUSY || state_q == ST_DONE)
                                     || cs_n_s;
                    bus.wait_out  <= state_q != ST_BUSY;
                end
                STYLE_ASTROBE: begin
                    // Ack high forces waits, low marks completion
                    bus.wait_oe_n <= !(state_q == ST_BUSY || state_q == ST_DONE)
                                     || cs_n_s;
                    bus.wait_out  <= state_q == ST_BUSY;
                end
                default: begin
                    // Enable-clock style leaves the pin floating
                    bus.wait_oe_n <= 1'b1;
                    bus.wait_out  <= 1'b1;
                end
            endcase
            if (state_q == ST_DONE && is_rd_q && !ack_done_q) begin
                bus.data_d <= rd_data_i;
            end
            // Generic style drives only while read strobe low
            bus.data_d_oe_n <= !(is_rd_q && !cs_n_s && state_q != ST_IDLE &&
                (style_o == STYLE_GENERIC ? !rd_s : 1'b1));
        end
    end
endmodule : host_bus_device

/* logic/host_bus_host.sv */
// Host end driving the parallel host bus port
module host_bus_host
    import host_bus_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    host_bus_if.host         bus,
    input  wire logic [1:0]  style_i,
    input  wire logic        req_i,
    input  wire logic        req_wr_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [7:0]  req_data_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             timeout_o,
    output logic [7:0]       rd_data_o
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_END} host_state_e;

    host_state_e state_q;
    logic [2:0]  ph_q;
    logic [5:0]  to_q;
    logic        wr_q;
    logic [1:0]  w_sync_q, oe_sync_q;
    logic [7:0]  d_meta_q, d_sync_q;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            w_sync_q  <= 2'h3;
            oe_sync_q <= 2'h3;
            d_meta_q  <= DATA_RST;
            d_sync_q  <= DATA_RST;
        end else begin
            w_sync_q  <= {w_sync_q[0], bus.wait_out};
            oe_sync_q <= {oe_sync_q[0], bus.wait_oe_n};
            d_meta_q  <= bus.data_d;
            d_sync_q  <= d_meta_q;
        end
    end

    logic released, done_seen;
    always_comb begin
        released  = oe_sync_q[1];
        done_seen = !oe_sync_q[1] && (style_i == STYLE_ASTROBE ? !w_sync_q[1] : w_sync_q[1]);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q             <= H_IDLE;
            ph_q                <= 3'h0;
            to_q                <= 6'h00;
            wr_q                <= 1'b0;
            busy_o              <= 1'b0;
            done_o              <= 1'b0;
            timeout_o           <= 1'b0;
            rd_data_o           <= DATA_RST;
            bus.addr            <= ADDR_RST;
            bus.data_h          <= DATA_RST;
            bus.data_h_oe_n     <= 1'b1;
            bus.rd_pin          <= 1'b1;
            bus.wr_pin          <= 1'b1;
            bus.chip_sel_n      <= 1'b1;
            bus.addr_qualify_n  <= 1'b1;
            bus.bus_style_select <= STYLE_GENERIC;
            bus.scan_test_in    <= 1'b0;
            bus.factory_test_in <= 1'b0;
        end else begin
            bus.bus_style_select <= style_i;
            bus.scan_test_in     <= 1'b0;
            bus.factory_test_in  <= 1'b0;
            done_o    <= 1'b0;
            timeout_o <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    bus.rd_pin <= style_i != STYLE_ENCLK;
                    if (req_i) begin
                        state_q        <= H_SETUP;
                        busy_o         <= 1'b1;
                        wr_q           <= req_wr_i;
                        bus.addr       <= req_addr_i;
                        bus.data_h     <= req_data_i;
                        bus.chip_sel_n <= 1'b0;
                        bus.data_h_oe_n <= !req_wr_i;
                        bus.wr_pin     <= style_i == STYLE_GENERIC ? 1'b1 : !req_wr_i;
                        // Qualify stays high outside strobe style
                        bus.addr_qualify_n <= style_i != STYLE_ASTROBE;
                        ph_q <= HOST_CNT;
                    end
                end
                H_SETUP: begin
                    if (ph_q == 3'h0) begin
                        state_q <= H_STROBE;
                        ph_q    <= HOST_CNT;
                        to_q    <= HOST_TIMEOUT;
                        if (style_i == STYLE_GENERIC) begin
                            bus.wr_pin <= !wr_q;
                            bus.rd_pin <= wr_q;
                        end else begin
                            bus.rd_pin <= style_i == STYLE_ENCLK;
                        end
                    end else begin
                        ph_q <= ph_q - 3'h1;
                    end
                end
                H_STROBE: begin
                    if (ph_q != 3'h0) begin
                        ph_q <= ph_q - 3'h1;
                    end else if (done_seen || (style_i == STYLE_ENCLK && to_q == ENCLK_END)) begin
                        state_q <= H_WAIT;
                    end else if (to_q == 6'h00) begin
                        state_q   <= H_WAIT;
                        timeout_o <= 1'b1;
                    end else begin
                        to_q <= to_q - 6'h01;
                    end
                end
                H_WAIT: begin
                    rd_data_o       <= d_sync_q;
                    state_q         <= H_END;
                    bus.wr_pin      <= 1'b1;
                    bus.rd_pin      <= style_i != STYLE_ENCLK;
                    bus.data_h_oe_n <= 1'b1;
                end
                H_END: begin
                    bus.chip_sel_n     <= 1'b1;
                    bus.addr_qualify_n <= 1'b1;
                    // Next access only after the pin is released
                    if (released || style_i == STYLE_ENCLK) begin
                        state_q <= H_IDLE;
                        busy_o  <= 1'b0;
                        done_o  <= 1'b1;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end
endmodule : host_bus_host

/* bench/host_bus_properties.sv */
// Concurrent checks on the pins between host and device ends
module host_bus_properties
    import host_bus_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       rd_pin,
    input  wire logic       wr_pin,
    input  wire logic       chip_sel_n,
    input  wire logic       addr_qualify_n,
    input  wire logic       data_d_oe_n,
    input  wire logic       wait_out,
    input  wire logic       wait_oe_n,
    input  wire logic [1:0] bus_style_select,
    input  wire logic       scan_test_in,
    input  wire logic       factory_test_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic gen_w;
    logic ast_w;
    assign gen_w = (bus_style_select == STYLE_GENERIC);
    assign ast_w = (bus_style_select == STYLE_ASTROBE);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    property p_wait_low_first;
        $fell(wait_oe_n) && gen_w |-> !wait_out;
    endproperty
    property p_wait_done;
        $fell(wait_oe_n) && gen_w |-> ##[1:10] (!wait_oe_n && wait_out);
    endproperty
    property p_ack_high_first;
        $fell(wait_oe_n) && ast_w |-> wait_out;
    endproperty
    property p_ack_done;
        $fell(wait_oe_n) && ast_w |-> ##[1:10] (!wait_oe_n && !wait_out);
    endproperty
    property p_enclk_float;
        (bus_style_select == STYLE_ENCLK) [*5] |-> wait_oe_n;
    endproperty
    property p_read_drive_gated;
        (gen_w && rd_pin) [*5] |-> data_d_oe_n;
    endproperty
    // Sync delay on chip select, so release is allowed a few cycles
    property p_deselect_release;
        chip_sel_n [*6] |-> (wait_oe_n && data_d_oe_n);
    endproperty
    property p_qualify_high;
        !ast_w |-> addr_qualify_n;
    endproperty
    property p_test_low;
        !scan_test_in && !factory_test_in;
    endproperty
    property p_handshake;
        gen_w && !wait_oe_n && !wait_out && !(rd_pin && wr_pin)
            |=> !chip_sel_n && $stable(rd_pin) && $stable(wr_pin);
    endproperty
    // Checked while reset is held, so the default disable is overridden
    property p_reset_quiet;
        @(posedge clk_sys_i) disable iff (1'b0)
            !resetn_i |-> (wait_oe_n && data_d_oe_n && chip_sel_n);
    endproperty

    a_wait_low_first: assert property (p_wait_low_first) else $error("wait not low first");
    a_wait_done: assert property (p_wait_done) else $error("wait never completed");
    a_ack_high_first: assert property (p_ack_high_first) else $error("ack not high first");
    a_ack_done: assert property (p_ack_done) else $error("ack never completed");
    a_enclk_float: assert property (p_enclk_float) else $error("wait driven in enable mode");
    a_read_drive_gated: assert property (p_read_drive_gated) else $error("data driven, no read");
    a_deselect_release: assert property (p_deselect_release) else $error("drive while idle");
    a_qualify_high: assert property (p_qualify_high) else $error("qualify not held high");
    a_test_low: assert property (p_test_low) else $error("test input not low");
    a_handshake: assert property (p_handshake) else $error("host left during wait");
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");

    c_generic_wait: cover property ($fell(wait_oe_n) && gen_w);
    c_strobe_ack: cover property ($fell(wait_oe_n) && ast_w);
    c_read_drive: cover property ($fell(data_d_oe_n));
endmodule : host_bus_properties

/* bench/test_host_bus_control_signals.sv */
// Self-checking bench joining the host and device ends of the port
module test_host_bus_control_signals;
    timeunit 1ns;
    timeprecision 100ps;
    import host_bus_pkg::*;

    logic        clk_sys_i;
    logic        resetn_i;
    logic [1:0]  style;
    logic        req;
    logic        req_wr;
    logic [15:0] req_addr;
    logic [7:0]  req_data;
    logic        busy;
    logic        done;
    logic        timeout;
    logic [7:0]  rd_data_h;
    logic        wr_valid;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        rd_req;
    logic [15:0] rd_addr;
    logic [7:0]  rd_data_dev;
    logic [1:0]  style_o;
    logic [23:0] wr_notes[$];
    logic [15:0] rd_notes[$];
    logic [8:0]  done_notes[$];
    logic [8:0]  dn;
    logic [1:0]  styles[3] = '{STYLE_GENERIC, STYLE_ENCLK, STYLE_ASTROBE};
    integer      seed;
    int          fails;
    int          checks;

    host_bus_if bus_if ();

    host_bus_device host_bus_device_inst (
        .clk_sys_i (clk_sys_i), .resetn_i (resetn_i), .bus (bus_if),
        .wr_valid_o (wr_valid), .wr_addr_o (wr_addr), .wr_data_o (wr_data),
        .rd_req_o (rd_req), .rd_addr_o (rd_addr), .rd_data_i (rd_data_dev),
        .style_o (style_o)
    );
    host_bus_host host_bus_host_inst (
        .clk_sys_i (clk_sys_i), .resetn_i (resetn_i), .bus (bus_if), .style_i (style),
        .req_i (req), .req_wr_i (req_wr), .req_addr_i (req_addr), .req_data_i (req_data),
        .busy_o (busy), .done_o (done), .timeout_o (timeout), .rd_data_o (rd_data_h)
    );
    host_bus_properties host_bus_properties_inst (
        .clk_sys_i (clk_sys_i), .resetn_i (resetn_i), .rd_pin (bus_if.rd_pin),
        .wr_pin (bus_if.wr_pin), .chip_sel_n (bus_if.chip_sel_n),
        .addr_qualify_n (bus_if.addr_qualify_n), .data_d_oe_n (bus_if.data_d_oe_n),
        .wait_out (bus_if.wait_out), .wait_oe_n (bus_if.wait_oe_n),
        .bus_style_select (bus_if.bus_style_select), .scan_test_in (bus_if.scan_test_in),
        .factory_test_in (bus_if.factory_test_in)
    );

    always #2 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic wait_flag(ref logic f);
        int n;
        n = 0;
        while (f !== 1'b1 && n < 200) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 200) begin
            fails++;
            $display("mismatch at %0t: handshake hung", $time);
            complete_run();
        end
    endtask : wait_flag

    // One transfer at a time; the host accepts the next only after done
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] rv;
        rv = 8'($random(seed));
        @(posedge clk_sys_i);
        #1;
        rd_data_dev = rv;
        req = 1'b1;
        req_wr = wr;
        req_addr = a;
        req_data = d;
        if (wr) wr_notes.push_back({a, d});
        else rd_notes.push_back(a);
        done_notes.push_back({!wr, wr ? 8'h00 : rv});
        wait_flag(busy);
        req = 1'b0;
        wait_flag(done);
    endtask : xfer

    // Outputs are registered, so values seen at the edge are settled
    always @(posedge clk_sys_i) begin
        if (wr_valid === 1'b1) begin
            check(24'(wr_notes.size() > 0), 24'h1);
            if (wr_notes.size() > 0) check({wr_addr, wr_data}, wr_notes.pop_front());
        end
        if (rd_req === 1'b1) begin
            check(24'(rd_notes.size() > 0), 24'h1);
            if (rd_notes.size() > 0) check(24'(rd_addr), 24'(rd_notes.pop_front()));
        end
        if (done === 1'b1 && done_notes.size() > 0) begin
            dn = done_notes.pop_front();
            if (dn[8]) check(24'(rd_data_h), 24'(dn[7:0]));
        end
        if (timeout === 1'b1) check(24'h1, 24'h0);
    end

    initial begin
        seed = 79;
        clk_sys_i = 1'b0;
        resetn_i = 1'b1;
        style = STYLE_GENERIC;
        req = 1'b0;
        req_wr = 1'b0;
        req_addr = 16'h0000;
        req_data = 8'h00;
        rd_data_dev = 8'h00;
        fails = 0;
        checks = 0;
        // Drop after time zero so every async reset sees the edge
        #1 resetn_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1 resetn_i = 1'b1;
        foreach (styles[i]) begin
            style = styles[i];
            repeat (8) @(posedge clk_sys_i);
            #1;
            check(24'(style_o), 24'(style));
            for (int k = 0; k < 8; k++) begin
                xfer(k[0], k == 2 ? 16'hffff : 16'($random(seed)), 8'($random(seed)));
            end
            repeat (12) @(posedge clk_sys_i);
            #1;
            check(24'(wr_notes.size() + rd_notes.size()), 24'h0);
            check({bus_if.scan_test_in, bus_if.factory_test_in}, 24'h0);
            check({bus_if.chip_sel_n, bus_if.addr_qualify_n}, 24'h3);
            check({bus_if.wait_oe_n, bus_if.data_d_oe_n}, 24'h3);
            $display("test style %0d done", style);
        end
        // Abort a write in mid-transfer with a second reset
        style = STYLE_GENERIC;
        @(posedge clk_sys_i);
        #1;
        req = 1'b1;
        req_wr = 1'b1;
        repeat (7) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b0;
        req = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check({bus_if.wait_oe_n, bus_if.data_d_oe_n, bus_if.chip_sel_n}, 24'h7);
        check({style_o, wr_valid, rd_req, busy}, 24'h0);
        wr_notes.delete();
        rd_notes.delete();
        done_notes.delete();
        resetn_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        xfer(1'b1, 16'h0001, 8'ha5);
        xfer(1'b0, 16'h0001, 8'h00);
        repeat (8) @(posedge clk_sys_i);
        $display("test reset recovery done");
        complete_run();
    end
endmodule : test_host_bus_control_signals
